// File: rtl/uart_nine_bit_modes.sv
// Serial port core for the eleven-bit frame modes with its register port
`include "uart9_cfg.svh"
`default_nettype none
// Operation
// R1 - Eleven bits: start, eight LSB-first, ninth, stop
// R2 - Sent ninth bit follows tx_ninth_bit
// R3 - Received ninth bit lands in rx_ninth_bit
// R4 - Fixed mode: osc/32, osc/16 when doubled
// R5 - Variable mode: timer 1 (osc/6) or generator
// R6 - Buffer write loads ninth bit, requests send
// R7 - Send begins at next counter rollover
// R8 - Start bit, data one bit later, shift after
// R9 - First shift inserts one, then zeroes
// R10 - Stop beside ninth: last shift, done, roll 11
// R11 - Hunt falling edge at sixteen times rate
// R12 - Edge clears counter, loads all ones
// R13 - Majority of samples at states 7, 8, 9
// R14 - Nonzero start bit: back to hunting
// R15 - Start bit leftmost: final shift and load
// R16 - Load only if flag clear and filter passes
// R17 - Load byte, ninth bit, set rx_done_flag
// R18 - One bit after final shift, hunt again
// R19 - Stop bit value affects nothing
// R20 - Software clears rx_done_flag after reading
module uart_nine_bit_modes (
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  input  wire uart9_pkg::reg_req_s bus_in,
  output logic [7:0]               rdata_out,
  input  wire logic                rxd_in,
  output logic                     txd_out
);
  import uart9_pkg::*;

  localparam logic [7:0] CTRL_RST = `CONTROL_RST;
  localparam logic [7:0] PWR_RST  = `POWER_RST;
  localparam logic [7:0] SEL_RST  = `BAUD_SEL_RST;

  logic       rst_meta;
  logic       rst_n;
  logic       variable_mode;
  logic       multiproc_filter;
  logic       rx_en;
  logic       tx_ninth_bit;
  logic       rx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic       baud_double;
  logic       bg_sel;
  logic [7:0] t1_reload;
  logic [9:0] bg_reload;
  logic [7:0] serial_buffer;
  logic [7:0] next_rdata;
  logic       wr_ctrl;
  logic       wr_buf;
  logic [2:0] t1_pre;
  logic       t1_step;
  logic [7:0] t1_cnt;
  logic       t1_ovf;
  logic [9:0] bg_cnt;
  logic       bg_ovf;
  logic       src_tick;
  logic       half;
  logic       tick16;
  logic [8:0] tx_sh;
  logic       tx_req;
  logic       send;
  logic       data_ph;
  logic       shifted;
  logic       tx_roll;
  logic       tx_accept;
  logic       tx_last;
  logic       tx_fin;
  logic [3:0] roll_cnt;
  rx_state_e  rx_state;
  logic       rxd_q;
  logic       rxd_prev;
  logic       s_a;
  logic       s_b;
  logic       first_bit;
  logic       maj;
  logic [8:0] rx_sh;
  logic [3:0] rx_cnt;
  logic       rx_edge;
  logic       sample_c;
  logic       final_sh;
  logic       rx_load;
  logic [7:0] rx_byte;
  logic [4:0] tail_ticks;

  // Reset is released through two flops so every flop leaves reset together
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign wr_ctrl = bus_in.wr && (bus_in.addr == `REG_CONTROL);
  assign wr_buf  = bus_in.wr && (bus_in.addr == `REG_BUFFER);

  // Software-owned configuration
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      variable_mode <= CTRL_RST[`CTL_VARIABLE];
      multiproc_filter <= CTRL_RST[`CTL_FILTER];
      rx_en <= CTRL_RST[`CTL_RX_EN];
      tx_ninth_bit <= CTRL_RST[`CTL_TX_NINTH];
      baud_double <= PWR_RST[`PWR_DOUBLE];
      bg_sel <= SEL_RST[`SEL_BAUD_GEN];
      t1_reload <= `T1_RELOAD_RST;
      bg_reload <= `BG_RELOAD_RST;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        `REG_CONTROL: begin
          variable_mode <= bus_in.wdata[`CTL_VARIABLE];
          multiproc_filter <= bus_in.wdata[`CTL_FILTER];
          rx_en <= bus_in.wdata[`CTL_RX_EN];
          tx_ninth_bit <= bus_in.wdata[`CTL_TX_NINTH];
        end
        `REG_POWER: begin
          baud_double <= bus_in.wdata[`PWR_DOUBLE];
        end
        `REG_BAUD_SEL: begin
          bg_sel <= bus_in.wdata[`SEL_BAUD_GEN];
        end
        `REG_T1_RELOAD: begin
          t1_reload <= bus_in.wdata;
        end
        `REG_BG_LOW: begin
          bg_reload[7:0] <= bus_in.wdata;
        end
        `REG_BG_HIGH: begin
          bg_reload[9:8] <= bus_in.wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Hardware events win over a software write in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_flag <= CTRL_RST[`CTL_TX_DONE];
    end else if (tx_fin) begin
      tx_done_flag <= 1'b1; // R10
    end else if (wr_ctrl) begin
      tx_done_flag <= bus_in.wdata[`CTL_TX_DONE];
    end
  end

  // Never cleared here: software must clear it or later frames are dropped
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_flag <= CTRL_RST[`CTL_RX_DONE];
    end else if (rx_load) begin
      rx_done_flag <= 1'b1; // R17
    end else if (wr_ctrl) begin
      rx_done_flag <= bus_in.wdata[`CTL_RX_DONE]; // R20
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_ninth_bit <= CTRL_RST[`CTL_RX_NINTH];
      serial_buffer <= 8'h00;
    end else if (rx_load) begin
      rx_ninth_bit <= maj; // R3
      serial_buffer <= rx_byte; // R17
    end else if (wr_ctrl) begin
      rx_ninth_bit <= bus_in.wdata[`CTL_RX_NINTH];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (bus_in.addr)
      `REG_CONTROL: begin
        next_rdata[`CTL_VARIABLE] = variable_mode;
        next_rdata[`CTL_FILTER] = multiproc_filter;
        next_rdata[`CTL_RX_EN] = rx_en;
        next_rdata[`CTL_TX_NINTH] = tx_ninth_bit;
        next_rdata[`CTL_RX_NINTH] = rx_ninth_bit;
        next_rdata[`CTL_TX_DONE] = tx_done_flag;
        next_rdata[`CTL_RX_DONE] = rx_done_flag;
      end
      `REG_BUFFER: next_rdata = serial_buffer;
      `REG_POWER: next_rdata[`PWR_DOUBLE] = baud_double;
      `REG_BAUD_SEL: next_rdata[`SEL_BAUD_GEN] = bg_sel;
      `REG_T1_RELOAD: next_rdata = t1_reload;
      `REG_BG_LOW: next_rdata = bg_reload[7:0];
      `REG_BG_HIGH: next_rdata[1:0] = bg_reload[9:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Timer 1 counts at oscillator / 6 and reloads on overflow
  assign t1_step = (t1_pre == (`T1_PRESCALE - 3'h1));
  assign t1_ovf  = t1_step && (t1_cnt == 8'hff);

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      t1_pre <= 3'h0;
      t1_cnt <= `T1_RELOAD_RST;
    end else begin
      t1_pre <= t1_step ? 3'h0 : t1_pre + 3'h1; // R5
      if (t1_ovf) begin
        t1_cnt <= t1_reload;
      end else if (t1_step) begin
        t1_cnt <= t1_cnt + 8'h01;
      end
    end
  end

  assign bg_ovf = (bg_cnt == 10'h3ff);

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      bg_cnt <= `BG_RELOAD_RST;
    end else begin
      bg_cnt <= bg_ovf ? bg_reload : bg_cnt + 10'h001; // R5
    end
  end

  // Fixed mode sees the oscillator as its overflow source; halving unless doubled
  assign src_tick = !variable_mode ? 1'b1 : (bg_sel ? bg_ovf : t1_ovf); // R5
  assign tick16   = src_tick && (baud_double || half); // R4

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      half <= 1'b0;
    end else if (src_tick) begin
      half <= ~half;
    end
  end

  bit_counter #(
    .WIDTH (4)
  ) u_tx_div (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .tick_in   (tick16),
    .clear_in  (1'b0),
    .count_out (),
    .roll_out  (tx_roll)
  );

  // A write while a frame is pending or running is ignored, not queued
  assign tx_accept = wr_buf && !tx_req && !send;
  assign tx_last   = send && data_ph && shifted && (tx_sh[8:2] == 7'h00) && tx_sh[1]; // R10
  assign tx_fin    = tx_roll && tx_last;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh <= 9'h000;
      tx_req <= 1'b0;
      send <= 1'b0;
      data_ph <= 1'b0;
      shifted <= 1'b0;
      txd_out <= 1'b1;
    end else if (tx_accept) begin
      tx_sh <= {tx_ninth_bit, bus_in.wdata}; // R2 R6
      tx_req <= 1'b1;
    end else if (tx_roll) begin
      if (tx_req) begin
        send <= 1'b1; // R7
        tx_req <= 1'b0;
        data_ph <= 1'b0;
        shifted <= 1'b0;
        txd_out <= 1'b0; // R8
      end else if (send && !data_ph) begin
        data_ph <= 1'b1;
        txd_out <= tx_sh[0]; // R8
      end else if (send) begin
        tx_sh <= {!shifted, tx_sh[8:1]}; // R9
        txd_out <= tx_sh[1]; // R1
        shifted <= 1'b1;
        if (tx_last) begin
          send <= 1'b0; // R10
          data_ph <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      roll_cnt <= 4'h0;
    end else if (tx_accept) begin
      roll_cnt <= 4'h0;
    end else if (tx_roll && (tx_req || send)) begin
      roll_cnt <= roll_cnt + 4'h1;
    end
  end

  // Line is taken as synchronous; one flop only aligns it with the samplers
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_in;
    end
  end

  assign rx_edge = (rx_state == RX_HUNT) && rx_en && tick16 && rxd_prev && !rxd_q; // R11

  bit_counter #(
    .WIDTH (4)
  ) u_rx_div (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .tick_in   (tick16),
    .clear_in  (rx_edge),
    .count_out (rx_cnt),
    .roll_out  ()
  );

  assign maj      = (s_a && s_b) || (s_a && rxd_q) || (s_b && rxd_q); // R13
  assign sample_c = (rx_state != RX_HUNT) && tick16 && (rx_cnt == `SAMPLE_C);
  assign final_sh = (rx_state == RX_BITS) && sample_c && !rx_sh[8]; // R15
  assign rx_load  = final_sh && !rx_done_flag && (!multiproc_filter || maj); // R16
  // The first data bit sits deepest in the register, so the byte is reversed
  assign rx_byte  = {<<{rx_sh[7:0]}};

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_a <= 1'b1;
      s_b <= 1'b1;
      rxd_prev <= 1'b1;
    end else if (tick16) begin
      rxd_prev <= rxd_q;
      if (rx_cnt == `SAMPLE_A) begin
        s_a <= rxd_q; // R13
      end
      if (rx_cnt == `SAMPLE_B) begin
        s_b <= rxd_q; // R13
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_HUNT;
      rx_sh <= `RX_SH_INIT;
      first_bit <= 1'b0;
    end else begin
      unique case (rx_state)
        RX_HUNT: begin
          if (rx_edge) begin
            rx_sh <= `RX_SH_INIT; // R12
            first_bit <= 1'b1;
            rx_state <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (sample_c) begin
            first_bit <= 1'b0;
            rx_sh <= {rx_sh[7:0], maj}; // R15
            if (first_bit && maj) begin
              rx_state <= RX_HUNT; // R14
            end else if (!rx_sh[8]) begin
              rx_state <= RX_TAIL;
            end
          end
        end
        RX_TAIL: begin
          // Stop bit time: its value is never looked at
          if (sample_c) begin
            rx_state <= RX_HUNT; // R18 R19
          end
        end
        default: begin
          rx_state <= RX_HUNT;
        end
      endcase
    end
  end

  // Ticks spent in the stop bit time, so the return to hunting can be timed at any rate
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      tail_ticks <= 5'h00;
    end else if (rx_state != RX_TAIL) begin
      tail_ticks <= 5'h00;
    end else if (tick16) begin
      tail_ticks <= tail_ticks + 5'h01;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  AST_FIXED_DOUBLE: assert property ( // R4
    !variable_mode && baud_double |-> tick16
  ) else $error("fixed doubled rate lost a tick");
  AST_TX_LOAD: assert property ( // R6
    tx_accept |=> tx_req && tx_sh[8] == $past(tx_ninth_bit)
  ) else $error("ninth bit not loaded on buffer write");
  AST_TX_ALIGN: assert property ( // R7
    $rose(send) |-> $past(tx_roll) && !tx_req
  ) else $error("send began off a rollover");
  AST_TX_START: assert property ( // R8
    send && !data_ph |-> !txd_out
  ) else $error("start bit not held for a bit time");
  AST_TX_FIRST: assert property ( // R9
    tx_roll && send && data_ph && !shifted |=> tx_sh[8] && shifted
  ) else $error("first shift did not insert a one");
  AST_TX_NINTH_OUT: assert property ( // R2
    $rose(tx_last) |-> txd_out == tx_sh[0]
  ) else $error("ninth bit not on line");
  AST_TX_ELEVEN: assert property ( // R10
    tx_fin |-> roll_cnt == (`TX_FRAME_ROLLS - 4'h1) ##1 (tx_done_flag && txd_out && !send)
  ) else $error("transmit did not end at eleventh rollover");
  AST_RX_EDGE: assert property ( // R12
    rx_edge |=> rx_sh == `RX_SH_INIT && rx_cnt == 4'h0 && rx_state == RX_BITS
  ) else $error("edge did not restart receiver");
  AST_RX_FALSE: assert property ( // R14
    sample_c && first_bit && maj && rx_state == RX_BITS |=> rx_state == RX_HUNT
  ) else $error("false start bit not rejected");
  AST_RX_COND: assert property ( // R16
    final_sh && !wr_ctrl && (rx_done_flag || (multiproc_filter && !maj))
      |=> $stable(rx_done_flag) && $stable(serial_buffer) && $stable(rx_ninth_bit)
  ) else $error("load taken with conditions unmet");
  AST_RX_SET: assert property ( // R17
    rx_load |=> rx_done_flag && rx_ninth_bit == $past(maj) && serial_buffer == $past(rx_byte)
  ) else $error("received frame not stored");
  AST_RX_RETURN: assert property ( // R18
    final_sh |=> rx_state == RX_TAIL
  ) else $error("receiver did not enter stop bit time");
  AST_RX_TAIL_END: assert property ( // R18
    rx_state == RX_TAIL && tick16 && tail_ticks == 5'h0f |=> rx_state == RX_HUNT
  ) else $error("receiver did not return to hunting");
  AST_RX_TAIL_LEN: assert property ( // R18
    rx_state == RX_TAIL |-> tail_ticks <= 5'h0f
  ) else $error("stop bit time overran one bit");

  COV_TX_FRAME: cover property (tx_fin);
  COV_RX_LOAD: cover property (rx_load);
  COV_RX_FALSE: cover property (sample_c && first_bit && maj && rx_state == RX_BITS);
  COV_RX_DROP: cover property (final_sh && !rx_load);
endmodule
`default_nettype wire

// File: rtl/uart9_cfg.svh
// Register offsets, field positions, reset values and counts of the serial port
`ifndef UART9_CFG_SVH
`define UART9_CFG_SVH
`define REG_CONTROL    3'h0
`define REG_BUFFER     3'h1
`define REG_POWER      3'h2
`define REG_BAUD_SEL   3'h3
`define REG_T1_RELOAD  3'h4
`define REG_BG_LOW     3'h5
`define REG_BG_HIGH    3'h6
`define CTL_VARIABLE   6
`define CTL_FILTER     5
`define CTL_RX_EN      4
`define CTL_TX_NINTH   3
`define CTL_RX_NINTH   2
`define CTL_TX_DONE    1
`define CTL_RX_DONE    0
`define PWR_DOUBLE     7
`define SEL_BAUD_GEN   0
`define CONTROL_RST    8'h00
`define POWER_RST      8'h00
`define BAUD_SEL_RST   8'h00
`define T1_RELOAD_RST  8'h00
`define BG_RELOAD_RST  10'h3d9
`define RX_SH_INIT     9'h1ff
`define T1_PRESCALE    3'h6
`define SAMPLE_A       4'h7
`define SAMPLE_B       4'h8
`define SAMPLE_C       4'h9
`define TX_FRAME_ROLLS 4'hb
`endif

// File: rtl/uart9_pkg.sv
// Types shared by the serial port design files
`default_nettype none
package uart9_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
  typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_TAIL} rx_state_e;
endpackage
`default_nettype wire

// File: rtl/bit_counter.sv
// Divide-by-16 bit-time counter with synchronous clear and rollover pulse
`default_nettype none
module bit_counter #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             tick_in,
  input  wire logic             clear_in,
  output logic [WIDTH-1:0]      count_out,
  output logic                  roll_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= '0;
    end else if (clear_in) begin
      count_out <= '0;
    end else if (tick_in) begin
      count_out <= count_out + 1'b1;
    end
  end

  assign roll_out = tick_in && !clear_in && (count_out == '1);
endmodule
`default_nettype wire

// File: dv/serial_node.sv
// Remote serial node: sends and decodes eleven-bit frames
`default_nettype none
module serial_node (
  input  wire logic        clk_in,
  input  wire logic [15:0] bit_clks_in,
  input  wire logic        go_in,
  input  wire logic [10:0] frame_in,
  input  wire logic        short_in,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             busy_out,
  output logic [10:0]      got_out,
  output logic [7:0]       got_cnt_out
);
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
    got_out = '0;
    got_cnt_out = '0;
  end
  // Sender; a short pulse is a false start that must not pass the vote
  always begin
    @(posedge clk_in);
    if (go_in) begin
      busy_out <= 1'b1;
      if (short_in) begin
        line_out <= 1'b0;
        repeat (bit_clks_in / 4) @(posedge clk_in);
      end else begin
        for (int i = 0; i < 11; i++) begin
          line_out <= frame_in[i];
          repeat (bit_clks_in) @(posedge clk_in);
        end
      end
      line_out <= 1'b1;
      busy_out <= 1'b0;
    end
  end
  // Receiver samples mid-bit, so small phase offsets do not matter
  always begin
    @(negedge line_in);
    repeat (bit_clks_in / 2) @(posedge clk_in);
    for (int j = 0; j < 11; j++) begin
      got_out[j] <= line_in;
      if (j < 10) repeat (bit_clks_in) @(posedge clk_in);
    end
    got_cnt_out <= got_cnt_out + 8'h01;
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the eleven-bit serial port
`include "uart9_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uart9_pkg::*;
  logic        mclk_in;
  logic        rst_n_in;
  reg_req_s    bus;
  logic [7:0]  rdata;
  logic        rxd;
  logic        txd;
  logic [15:0] bit_clks;
  logic        go;
  logic        short_start;
  logic [10:0] frame;
  logic        busy;
  logic [10:0] got;
  logic [7:0]  got_cnt;
  logic [31:0] seed;
  int          bad_count;
  int          checks;
  logic [7:0]  pwr_t [4] = '{8'h80, 8'h00, 8'h80, 8'h00};
  logic        var_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic        sel_t [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int          bits_t [4] = '{16, 32, 96, 32};

  uart_nine_bit_modes u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rdata), .rxd_in(rxd), .txd_out(txd));
  serial_node u_node (
    .clk_in(mclk_in), .bit_clks_in(bit_clks), .go_in(go), .frame_in(frame),
    .short_in(short_start), .line_in(txd), .line_out(rxd), .busy_out(busy),
    .got_out(got), .got_cnt_out(got_cnt));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic n, input logic s);
    return {s, n, d, 1'b0};
  endfunction
  function automatic logic [7:0] ctl(input logic v, input logic f, input logic t);
    return {1'b0, v, f, 1'b1, t, 3'b000};
  endfunction

  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic send(input logic [10:0] f, input logic s);
    int n = 0;
    @(posedge mclk_in);
    frame <= f;
    short_start <= s;
    go <= 1'b1;
    @(posedge mclk_in);
    go <= 1'b0;
    @(posedge mclk_in);
    while (busy && n < 20000) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (2 * bit_clks) @(posedge mclk_in);
  endtask
  task automatic results;
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk_in);
    bad_count++;
    results();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] e;
    logic       n;
    int         k;
    rst_n_in = 1'b0;
    bus = '0;
    go = 1'b0;
    short_start = 1'b0;
    frame = '1;
    bit_clks = 16'd16;
    seed = 32'h2bf2;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    for (k = 0; k < 8; k++) begin
      rd(k[2:0], v);
      e = (k == 5) ? 8'hd9 : (k == 6) ? 8'h03 : 8'h00;
      check("reset value", {3'h0, e}, {3'h0, v});
    end
    wr(3'h7, 8'h5a);
    rd(3'h7, v);
    check("unmapped", 11'h000, {3'h0, v});
    wr(`REG_T1_RELOAD, 8'hff);
    wr(`REG_BG_LOW, 8'hff);
    wr(`REG_BG_HIGH, 8'h03);
    for (int m = 0; m < 4; m++) begin
      bit_clks <= 16'(bits_t[m]);
      wr(`REG_POWER, pwr_t[m]);
      wr(`REG_BAUD_SEL, {7'h00, sel_t[m]});
      seed = lfsr(seed);
      d = seed[7:0];
      n = seed[8];
      wr(`REG_CONTROL, ctl(var_t[m], 1'b0, n));
      e = got_cnt;
      wr(`REG_BUFFER, d);
      k = 0;
      while (txd === 1'b1 && k < 200) begin
        @(posedge mclk_in);
        k++;
      end
      check("start delay", 11'h001, {10'h000, k <= bits_t[m] + 1});
      wr(`REG_BUFFER, ~d);
      repeat (6 * bits_t[m]) @(posedge mclk_in);
      rd(`REG_CONTROL, v);
      check("tx busy flags", {3'h0, ctl(var_t[m], 1'b0, n)}, {3'h0, v});
      k = 0;
      while (got_cnt == e && k < 20 * bits_t[m]) begin
        @(posedge mclk_in);
        k++;
      end
      check("tx frame", frame_of(d, n, 1'b1), got);
      rd(`REG_CONTROL, v);
      check("tx done", {3'h0, ctl(var_t[m], 1'b0, n) | 8'h02}, {3'h0, v});
      wr(`REG_CONTROL, ctl(var_t[m], 1'b0, 1'b0));
      seed = lfsr(seed);
      d = seed[7:0];
      n = seed[8];
      send(frame_of(d, n, seed[9]), 1'b0);
      rd(`REG_CONTROL, v);
      e = ctl(var_t[m], 1'b0, 1'b0) | {5'h00, n, 2'b01};
      check("rx flags", {3'h0, e}, {3'h0, v});
      rd(`REG_BUFFER, v);
      check("rx byte", {3'h0, d}, {3'h0, v});
      send(frame_of(~d, 1'b1, 1'b1), 1'b0);
      rd(`REG_BUFFER, v);
      check("rx kept", {3'h0, d}, {3'h0, v});
      wr(`REG_CONTROL, ctl(var_t[m], 1'b1, 1'b0));
      send(frame_of(~d, 1'b0, 1'b1), 1'b0);
      rd(`REG_CONTROL, v);
      check("rx filtered", {3'h0, ctl(var_t[m], 1'b1, 1'b0)}, {3'h0, v});
      send(11'h000, 1'b1);
      send(frame_of(~d, 1'b1, 1'b0), 1'b0);
      rd(`REG_CONTROL, v);
      check("rx address", {3'h0, ctl(var_t[m], 1'b1, 1'b0) | 8'h05}, {3'h0, v});
      rd(`REG_BUFFER, v);
      check("rx byte two", {3'h0, ~d}, {3'h0, v});
    end
    results();
  end
endmodule
`default_nettype wire
